// >>> dfc_cfg.svh
/*
  Constants of the dual FIFO block: sizes, default offsets, register
  offsets and field positions. Assumes inclusion by bare name only.
*/
`ifndef DFC_CFG_SVH
`define DFC_CFG_SVH

// fifo geometry
`define DFC_DW 9
`define DFC_AW 8
`define DFC_CW 9
`define DFC_DEPTH 9'h100
`define DFC_CNT_ZERO 9'h000
`define DFC_DEF_OFS 8'h07

// register byte offsets
`define DFC_R_CTRL 8'h00
`define DFC_R_WDATA 8'h04
`define DFC_R_POPA 8'h08
`define DFC_R_POPB 8'h0C
`define DFC_R_OFS 8'h10
`define DFC_R_STAT 8'h14
`define DFC_R_IRQST 8'h18
`define DFC_R_IRQCLR 8'h1C
`define DFC_R_IRQEN 8'h20

// control fields
`define DFC_CTRL_W 7
`define DFC_CTRL_RST 7'h01
`define DFC_C_HOLD 0
`define DFC_C_APIN 1
`define DFC_C_BPIN 2
`define DFC_C_WIDE 3
`define DFC_C_AREN2 4
`define DFC_C_BREN2 5
`define DFC_C_RING 6

// data and offset fields
`define DFC_W_TYPE 31
`define DFC_W_BLO 9
`define DFC_O_SEL 8
`define DFC_IRQ_W 4
`define DFC_HSIZE_WORD 3'h2

`endif

// >>> dfc_ctl.sv
/*
  Controller end: AHB-Lite slave that drives the dual FIFO pins in
  single, width, priority, bidirectional or ring depth mode.
  Assumes one slave on the bus and the device on the same hclk.
*/
`timescale 1ns/1ps
`include "dfc_cfg.svh"
module dfc_ctl import dfc_pkg::*; (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // interrupt
    output logic irq,
    // fifo pins
    dfc_if.ctl link
);
    dfc_state_t state_r;
    logic [`DFC_CTRL_W-1:0] ctrl_r;
    logic [7:0] addr_r;
    logic wr_pend_r, ring_w_r, ring_r_r, pop_b_r;
    logic [`DFC_IRQ_W-1:0] irq_st_r, irq_en_r, ev;
    logic [3:0] prev_r;
    logic sel_ok, is_pop, wide, ring, push, ofs_ld;
    dfc_word_t a_din_r, b_din_r;
    logic a_wen_n_r, b_wen_n_r, a_pin_r, b_pin_r;
    logic a_ren_n_r, b_ren_n_r, a_ren2_n_r, b_ren2_n_r, rst_n_r;
    logic [31:0] stat, rmux;

    // decode of address phase and data phase actions
    assign sel_ok = hsel && htrans[1] && hready && (hsize == `DFC_HSIZE_WORD);
    assign is_pop = (haddr[7:0] == `DFC_R_POPA) || (haddr[7:0] == `DFC_R_POPB);
    assign wide = ctrl_r[`DFC_C_WIDE];
    assign ring = ctrl_r[`DFC_C_RING];
    assign push = wr_pend_r && (addr_r == `DFC_R_WDATA);
    assign ofs_ld = wr_pend_r && (addr_r == `DFC_R_OFS);

    // status word, composite empty and full flags from both fifos, almost flags of fifo A only
    always_comb begin
        stat = 32'h0000_0000;
        stat[3:0] = {link.a_almost_full_n, link.a_almost_empty_n,
                     link.a_full_flag_n, link.a_empty_flag_n};
        stat[7:4] = {link.b_almost_full_n, link.b_almost_empty_n,
                     link.b_full_flag_n, link.b_empty_flag_n};
        stat[8] = link.a_empty_flag_n && link.b_empty_flag_n;
        stat[9] = link.a_full_flag_n && link.b_full_flag_n;
        stat[10] = link.a_almost_empty_n;
        stat[11] = link.a_almost_full_n;
    end

    // read mux for zero wait registers
    always_comb begin
        rmux = 32'h0000_0000;
        case (haddr[7:0])
            `DFC_R_CTRL: rmux[`DFC_CTRL_W-1:0] = ctrl_r;
            `DFC_R_STAT: rmux = stat;
            `DFC_R_IRQST: rmux[`DFC_IRQ_W-1:0] = irq_st_r;
            `DFC_R_IRQEN: rmux[`DFC_IRQ_W-1:0] = irq_en_r;
            default: rmux = 32'h0000_0000;
        endcase
    end

    // bus phases and pop sequence
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= dfc_st_idle;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            addr_r <= 8'h00;
            wr_pend_r <= 1'b0;
            pop_b_r <= 1'b0;
        end else if (ce) begin
            hresp <= 1'b0;
            case (state_r)
                dfc_st_idle: begin
                    wr_pend_r <= sel_ok && hwrite;
                    if (sel_ok) addr_r <= haddr[7:0];
                    if (sel_ok && !hwrite && is_pop) begin
                        state_r <= dfc_st_pop;
                        hreadyout <= 1'b0;
                        pop_b_r <= haddr[7:0] == `DFC_R_POPB;
                    end else if (sel_ok && !hwrite) begin
                        hrdata <= rmux;
                    end
                end
                dfc_st_pop: begin
                    wr_pend_r <= 1'b0;
                    state_r <= dfc_st_hold;
                end
                dfc_st_hold: begin
                    hreadyout <= 1'b1;
                    state_r <= dfc_st_idle;
                    hrdata <= 32'h0000_0000;
                    if (wide) hrdata[17:0] <= {link.b_q, link.a_q};
                    else if (ring) hrdata[8:0] <= ring_r_r ? link.b_q : link.a_q;
                    else hrdata[8:0] <= pop_b_r ? link.b_q : link.a_q;
                end
                default: begin
                    state_r <= dfc_st_idle;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `DFC_CTRL_RST;
            irq_en_r <= 4'h0;
        end else if (ce && wr_pend_r) begin
            if (addr_r == `DFC_R_CTRL) ctrl_r <= hwdata[`DFC_CTRL_W-1:0];
            if (addr_r == `DFC_R_IRQEN) irq_en_r <= hwdata[`DFC_IRQ_W-1:0];
        end
    end

    // ring pointers, advanced per transfer in ring mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ring_w_r <= 1'b0;
            ring_r_r <= 1'b0;
        end else if (ce) begin
            if (!ring) begin
                ring_w_r <= 1'b0;
                ring_r_r <= 1'b0;
            end else begin
                if (push) ring_w_r <= !ring_w_r;
                if (state_r == dfc_st_hold) ring_r_r <= !ring_r_r;
            end
        end
    end

    // write side pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_din_r <= 9'h000;
            b_din_r <= 9'h000;
            a_wen_n_r <= 1'b1;
            b_wen_n_r <= 1'b1;
            a_pin_r <= 1'b0;
            b_pin_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else if (ce) begin
            rst_n_r <= !ctrl_r[`DFC_C_HOLD];
            a_wen_n_r <= 1'b1;
            b_wen_n_r <= 1'b1;
            // strap level while fifo reset is held, then enable or ring steering
            if (!rst_n_r) begin
                a_pin_r <= ctrl_r[`DFC_C_APIN];
                b_pin_r <= ctrl_r[`DFC_C_BPIN];
            end else begin
                a_pin_r <= ring ? !ring_w_r : 1'b1;
                b_pin_r <= ring ? ring_w_r : 1'b1;
            end
            if (push) begin
                if (wide) begin
                    a_din_r <= hwdata[8:0];
                    b_din_r <= hwdata[`DFC_W_BLO +: `DFC_DW];
                    a_wen_n_r <= 1'b0;
                    b_wen_n_r <= 1'b0;
                end else if (ring) begin
                    a_din_r <= hwdata[8:0];
                    b_din_r <= hwdata[8:0];
                    a_wen_n_r <= 1'b0;
                    b_wen_n_r <= 1'b0;
                end else if (hwdata[`DFC_W_TYPE]) begin
                    b_din_r <= hwdata[8:0];
                    b_wen_n_r <= 1'b0;
                end else begin
                    a_din_r <= hwdata[8:0];
                    a_wen_n_r <= 1'b0;
                end
            end else if (ofs_ld) begin
                // pin low with write enable loads the next offset
                if (hwdata[`DFC_O_SEL]) begin
                    b_din_r <= {1'b0, hwdata[7:0]};
                    b_pin_r <= 1'b0;
                    b_wen_n_r <= 1'b0;
                end else begin
                    a_din_r <= {1'b0, hwdata[7:0]};
                    a_pin_r <= 1'b0;
                    a_wen_n_r <= 1'b0;
                end
            end
        end
    end

    // read side pins, one cycle read strobe in pop state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_ren_n_r <= 1'b1;
            b_ren_n_r <= 1'b1;
            a_ren2_n_r <= 1'b0;
            b_ren2_n_r <= 1'b0;
        end else if (ce) begin
            a_ren2_n_r <= ring ? ring_r_r : ctrl_r[`DFC_C_AREN2];
            b_ren2_n_r <= ring ? !ring_r_r : ctrl_r[`DFC_C_BREN2];
            a_ren_n_r <= 1'b1;
            b_ren_n_r <= 1'b1;
            if (state_r == dfc_st_idle && sel_ok && !hwrite && is_pop) begin
                a_ren_n_r <= !(wide || ring || haddr[7:0] == `DFC_R_POPA);
                b_ren_n_r <= !(wide || ring || haddr[7:0] == `DFC_R_POPB);
            end
        end
    end

    // events: fifo became non-empty, almost full reached
    assign ev = {prev_r[3] && !link.b_almost_full_n, prev_r[2] && !link.a_almost_full_n,
                 !prev_r[1] && link.b_empty_flag_n, !prev_r[0] && link.a_empty_flag_n};

    // sticky status, set wins over clear, level interrupt
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_r <= 4'h3;
            irq_st_r <= 4'h0;
            irq <= 1'b0;
        end else if (ce) begin
            prev_r <= {link.b_almost_full_n, link.a_almost_full_n,
                       link.b_empty_flag_n, link.a_empty_flag_n};
            if (wr_pend_r && addr_r == `DFC_R_IRQCLR) irq_st_r <= (irq_st_r & ~hwdata[3:0]) | ev;
            else irq_st_r <= irq_st_r | ev;
            irq <= |(irq_st_r & irq_en_r);
        end
    end

    // pins out, all from flops
    assign link.fifo_rst_n = rst_n_r;
    assign link.a_din = a_din_r;
    assign link.b_din = b_din_r;
    assign link.a_write_en1_n = a_wen_n_r;
    assign link.b_write_en1_n = b_wen_n_r;
    assign link.a_write_en2_or_offset_load = a_pin_r;
    assign link.b_write_en2_or_offset_load = b_pin_r;
    assign link.a_read_enable1_n = a_ren_n_r;
    assign link.b_read_enable1_n = b_ren_n_r;
    assign link.a_read_enable_second = a_ren2_n_r;
    assign link.b_read_enable_second = b_ren2_n_r;
endmodule : dfc_ctl

// >>> dfc_dev.sv
/*
  Device end: two identical independent synchronous FIFOs A and B with
  strap-selected second write enable or offset load pin.
  Assumes all pins are synchronous to hclk and driven from flops.
*/
`timescale 1ns/1ps
`include "dfc_cfg.svh"
module dfc_dev import dfc_pkg::*; (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // pins
    dfc_if.dev link,
    // configuration caught at reset
    output logic a_second_we,
    output logic b_second_we
);
    logic [1:0] wen1_n, pin, ren1_n, ren2_n;
    dfc_word_t din [2];

    // gather per-fifo pins
    assign wen1_n = {link.b_write_en1_n, link.a_write_en1_n};
    assign pin = {link.b_write_en2_or_offset_load, link.a_write_en2_or_offset_load};
    assign ren1_n = {link.b_read_enable1_n, link.a_read_enable1_n};
    assign ren2_n = {link.b_read_enable_second, link.a_read_enable_second};
    assign din[0] = link.a_din;
    assign din[1] = link.b_din;

    for (genvar gi = 0; gi < 2; gi++) begin : g_fifo
        dfc_word_t mem [`DFC_DEPTH];
        dfc_word_t q_r;
        logic [`DFC_AW-1:0] wp_r, rp_r;
        logic [`DFC_CW-1:0] cnt_r, cnt_nxt;
        logic [7:0] eofs_r, fofs_r;
        logic ofs_sel_r, sec_r;
        logic e_n_r, f_n_r, ae_n_r, af_n_r;
        logic ofs_wr, ofs_rd, do_wr, do_rd;

        // offset access only in load mode with the pin low
        assign ofs_wr = !sec_r && !pin[gi] && !wen1_n[gi];
        assign ofs_rd = !sec_r && !pin[gi] && !ren1_n[gi];
        // write needs both enables; pin high also means no load
        assign do_wr = !wen1_n[gi] && pin[gi] && (cnt_r != `DFC_DEPTH);
        assign do_rd = !ren1_n[gi] && !ren2_n[gi] && !ofs_rd && (cnt_r != `DFC_CNT_ZERO);

        // strap sampled while fifo reset is held low
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sec_r <= 1'b0;
            end else if (ce && !link.fifo_rst_n) begin
                sec_r <= pin[gi];
            end
        end

        // word count after this cycle
        always_comb begin
            cnt_nxt = cnt_r;
            case ({do_wr, do_rd})
                2'b10: cnt_nxt = cnt_r + 9'h001;
                2'b01: cnt_nxt = cnt_r - 9'h001;
                default: cnt_nxt = cnt_r;
            endcase
        end

        // storage array
        always_ff @(posedge hclk) begin
            if (ce && do_wr) begin
                mem[wp_r] <= din[gi];
            end
        end

        // pointers and count, each fifo on its own
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                wp_r <= 8'h00;
                rp_r <= 8'h00;
                cnt_r <= `DFC_CNT_ZERO;
            end else if (ce) begin
                if (!link.fifo_rst_n) begin
                    wp_r <= 8'h00;
                    rp_r <= 8'h00;
                    cnt_r <= `DFC_CNT_ZERO;
                end else begin
                    if (do_wr) wp_r <= wp_r + 8'h01;
                    if (do_rd) rp_r <= rp_r + 8'h01;
                    cnt_r <= cnt_nxt;
                end
            end
        end

        // offset registers: empty first, then full
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                eofs_r <= `DFC_DEF_OFS;
                fofs_r <= `DFC_DEF_OFS;
                ofs_sel_r <= 1'b0;
            end else if (ce) begin
                if (!link.fifo_rst_n) begin
                    eofs_r <= `DFC_DEF_OFS;
                    fofs_r <= `DFC_DEF_OFS;
                    ofs_sel_r <= 1'b0;
                end else if (ofs_wr) begin
                    if (ofs_sel_r) fofs_r <= din[gi][7:0];
                    else eofs_r <= din[gi][7:0];
                    ofs_sel_r <= !ofs_sel_r;
                end else if (ofs_rd) begin
                    ofs_sel_r <= !ofs_sel_r;
                end
            end
        end

        // output word: data or offset readback
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                q_r <= 9'h000;
            end else if (ce) begin
                if (!link.fifo_rst_n) q_r <= 9'h000;
                else if (ofs_rd) q_r <= {1'b0, ofs_sel_r ? fofs_r : eofs_r};
                else if (do_rd) q_r <= mem[rp_r];
            end
        end

        // flags, active low, from the next count
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                e_n_r <= 1'b0;
                f_n_r <= 1'b1;
                ae_n_r <= 1'b0;
                af_n_r <= 1'b1;
            end else if (ce) begin
                if (!link.fifo_rst_n) begin
                    e_n_r <= 1'b0;
                    f_n_r <= 1'b1;
                    ae_n_r <= 1'b0;
                    af_n_r <= 1'b1;
                end else begin
                    e_n_r <= cnt_nxt != `DFC_CNT_ZERO;
                    f_n_r <= cnt_nxt != `DFC_DEPTH;
                    ae_n_r <= cnt_nxt > {1'b0, eofs_r};
                    af_n_r <= cnt_nxt < (`DFC_DEPTH - {1'b0, fofs_r});
                end
            end
        end
    end

    // pins and configuration out, all from flops
    assign link.a_q = g_fifo[0].q_r;
    assign link.b_q = g_fifo[1].q_r;
    assign link.a_empty_flag_n = g_fifo[0].e_n_r;
    assign link.b_empty_flag_n = g_fifo[1].e_n_r;
    assign link.a_full_flag_n = g_fifo[0].f_n_r;
    assign link.b_full_flag_n = g_fifo[1].f_n_r;
    assign link.a_almost_empty_n = g_fifo[0].ae_n_r;
    assign link.b_almost_empty_n = g_fifo[1].ae_n_r;
    assign link.a_almost_full_n = g_fifo[0].af_n_r;
    assign link.b_almost_full_n = g_fifo[1].af_n_r;
    assign a_second_we = g_fifo[0].sec_r;
    assign b_second_we = g_fifo[1].sec_r;
endmodule : dfc_dev

// >>> dfc_if.sv
/*
  Pins between the dual FIFO device and its controlling logic.
  Assumes both ends run on one common clock.
*/
`timescale 1ns/1ps
interface dfc_if;
    import dfc_pkg::*;
    logic fifo_rst_n;
    dfc_word_t a_din, b_din;
    logic a_write_en1_n, b_write_en1_n;
    logic a_write_en2_or_offset_load, b_write_en2_or_offset_load;
    logic a_read_enable1_n, b_read_enable1_n;
    logic a_read_enable_second, b_read_enable_second;
    dfc_word_t a_q, b_q;
    logic a_empty_flag_n, b_empty_flag_n;
    logic a_full_flag_n, b_full_flag_n;
    logic a_almost_empty_n, b_almost_empty_n;
    logic a_almost_full_n, b_almost_full_n;

    modport dev (
        input fifo_rst_n, a_din, b_din, a_write_en1_n, b_write_en1_n,
        input a_write_en2_or_offset_load, b_write_en2_or_offset_load,
        input a_read_enable1_n, b_read_enable1_n,
        input a_read_enable_second, b_read_enable_second,
        output a_q, b_q, a_empty_flag_n, b_empty_flag_n, a_full_flag_n, b_full_flag_n,
        output a_almost_empty_n, b_almost_empty_n, a_almost_full_n, b_almost_full_n
    );
    modport ctl (
        output fifo_rst_n, a_din, b_din, a_write_en1_n, b_write_en1_n,
        output a_write_en2_or_offset_load, b_write_en2_or_offset_load,
        output a_read_enable1_n, b_read_enable1_n,
        output a_read_enable_second, b_read_enable_second,
        input a_q, b_q, a_empty_flag_n, b_empty_flag_n, a_full_flag_n, b_full_flag_n,
        input a_almost_empty_n, b_almost_empty_n, a_almost_full_n, b_almost_full_n
    );
endinterface : dfc_if

// >>> dfc_pkg.sv
/*
  Types shared by both ends of the dual FIFO block.
  Assumes nothing of its surroundings.
*/
package dfc_pkg;
    typedef logic [8:0] dfc_word_t;
    // controller pop sequence, idle to pop to hold one bit at a time, hold back to idle two bits
    typedef enum logic [1:0] {
        dfc_st_idle = 2'b00,
        dfc_st_pop = 2'b01,
        dfc_st_hold = 2'b11
    } dfc_state_t;
endpackage : dfc_pkg

// >>> dfc_props.sv
/*
  Checks on the pins between the dual FIFO ends.
  Assumes it watches the shared link on hclk.
*/
`timescale 1ns/1ps
module dfc_props (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // controller side
    input wire logic fifo_rst_n,
    input wire logic a_write_en1_n,
    input wire logic a_write_en2_or_offset_load,
    input wire logic a_read_enable1_n,
    input wire logic a_read_enable_second,
    input wire logic b_write_en1_n,
    input wire logic b_read_enable1_n,
    // device side
    input wire logic a_empty_flag_n,
    input wire logic a_full_flag_n,
    input wire logic a_almost_empty_n,
    input wire logic a_almost_full_n,
    input wire logic b_empty_flag_n
);
    // one domain for all checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // flag pairs stay consistent
    ae_with_empty_a: assert property (!a_empty_flag_n |-> !a_almost_empty_n)
        else $error("almost empty high while empty");
    af_with_full_a: assert property (!a_full_flag_n |-> !a_almost_full_n)
        else $error("almost full high while full");
    flag_excl_a: assert property (a_empty_flag_n || a_full_flag_n)
        else $error("empty and full together");
    // writes need both enables, reads both read enables
    write_gate_a: assert property ($rose(a_empty_flag_n) |->
        $past(!a_write_en1_n && a_write_en2_or_offset_load))
        else $error("fifo a filled without write");
    full_gate_a: assert property ($fell(a_full_flag_n) |->
        $past(!a_write_en1_n && a_write_en2_or_offset_load))
        else $error("fifo a full without write");
    read_gate_a: assert property ($fell(a_empty_flag_n) && $past(fifo_rst_n) |->
        $past(!a_read_enable1_n && !a_read_enable_second))
        else $error("fifo a drained without read");
    // fifo reset puts flags at their start levels
    rst_flags_a: assert property (!fifo_rst_n |=> !a_empty_flag_n && a_full_flag_n
        && !a_almost_empty_n && a_almost_full_n)
        else $error("flags wrong after fifo reset");
    // fifo b moves only on its own enables
    b_indep_a: assert property ($changed(b_empty_flag_n) && $past(fifo_rst_n) |->
        $past(!b_write_en1_n || !b_read_enable1_n))
        else $error("fifo b moved without enable");
endmodule : dfc_props

// >>> dfc_tb.sv
/*
  Bench for the dual FIFO block: controller and device on one link.
  Assumes one 40 MHz hclk and a single AHB-Lite slave.
*/
`timescale 1ns/1ps
module dfc_tb;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d;} dfc_row_t;
    // bus side
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic ce = 1'h1;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, irq, a_sec, b_sec;
    int error_cnt = 0;
    int cmp_count = 0;
    // priority mode: A loads offsets, B strapped high
    dfc_row_t rows[27] = '{
        '{8'h00, 1'h0, 32'h1}, '{8'h24, 1'h0, 32'h0}, '{8'h00, 1'h1, 32'h5},
        '{8'h00, 1'h1, 32'h4},
        '{8'h14, 1'h0, 32'hAAA}, '{8'h10, 1'h1, 32'h3}, '{8'h10, 1'h1, 32'hFC},
        '{8'h10, 1'h1, 32'h105}, '{8'h04, 1'h1, 32'h11}, '{8'h04, 1'h1, 32'h80000022},
        '{8'h20, 1'h1, 32'hF}, '{8'h18, 1'h0, 32'h3}, '{8'h14, 1'h0, 32'hBBB},
        '{8'h08, 1'h0, 32'h11}, '{8'h0C, 1'h0, 32'h22}, '{8'h08, 1'h0, 32'h11},
        '{8'h1C, 1'h1, 32'h1}, '{8'h18, 1'h0, 32'h2}, '{8'h04, 1'h1, 32'h1},
        '{8'h04, 1'h1, 32'h2}, '{8'h04, 1'h1, 32'h3}, '{8'h04, 1'h1, 32'h4},
        '{8'h18, 1'h0, 32'h7}, '{8'h14, 1'h0, 32'h6A7}, '{8'h00, 1'h1, 32'h14},
        '{8'h08, 1'h0, 32'h11}, '{8'h14, 1'h0, 32'h6A7}
    };

    dfc_if dfc_if_inst ();
    dfc_ctl dfc_ctl_inst (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .link(dfc_if_inst));
    dfc_dev dfc_dev_inst (.hclk, .hresetn, .ce, .link(dfc_if_inst), .a_second_we(a_sec),
        .b_second_we(b_sec));
    dfc_props dfc_props_inst (.hclk, .hresetn, .fifo_rst_n(dfc_if_inst.fifo_rst_n),
        .a_write_en1_n(dfc_if_inst.a_write_en1_n),
        .a_write_en2_or_offset_load(dfc_if_inst.a_write_en2_or_offset_load),
        .a_read_enable1_n(dfc_if_inst.a_read_enable1_n),
        .a_read_enable_second(dfc_if_inst.a_read_enable_second),
        .b_write_en1_n(dfc_if_inst.b_write_en1_n),
        .b_read_enable1_n(dfc_if_inst.b_read_enable1_n),
        .a_empty_flag_n(dfc_if_inst.a_empty_flag_n),
        .a_full_flag_n(dfc_if_inst.a_full_flag_n),
        .a_almost_empty_n(dfc_if_inst.a_almost_empty_n),
        .a_almost_full_n(dfc_if_inst.a_almost_full_n),
        .b_empty_flag_n(dfc_if_inst.b_empty_flag_n));

    // 25 ns clock
    initial forever #12.5 hclk = ~hclk;

    // status word for equal counts in both fifos, offsets at seven
    function automatic logic [31:0] stat(input int c);
        logic [3:0] n;
        n = {c < 249, c > 7, c != 256, c != 0};
        return {20'h0, n, n, n};
    endfunction : stat

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one single transfer, waits on hready in both phases
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'h1;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        r = hrdata;
        repeat (4) @(posedge hclk);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'h0, 32'h0, r);
        chk($sformatf("reg %h", a), r, e);
    endtask : rd

    task give_verdict;
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // main sequence
    initial begin
        logic [31:0] r;
        int i;
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        foreach (rows[k]) begin
            if (rows[k].w)
                bus(rows[k].a, 1'h1, rows[k].d, r);
            else
                rd(rows[k].a, rows[k].d);
        end
        chk("straps", {30'h0, a_sec, b_sec}, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        bus(8'h20, 1'h1, 32'h0, r);
        chk("irq", {31'h0, irq}, 32'h0);
        // width mode, both strapped high: fill past full, then drain
        bus(8'h00, 1'h1, 32'h7, r);
        bus(8'h00, 1'h1, 32'hE, r);
        chk("straps", {30'h0, a_sec, b_sec}, 32'h3);
        bus(8'h10, 1'h1, 32'h1, r);
        for (i = 0; i <= 256; i++) begin
            bus(8'h04, 1'h1, {14'h0, ~9'(i), 9'(i)}, r);
            rd(8'h14, stat(i < 256 ? i + 1 : 256));
        end
        for (i = 0; i < 256; i++) begin
            rd(8'h08, {14'h0, ~9'(i), 9'(i)});
            rd(8'h14, stat(255 - i));
        end
        rd(8'h0C, {14'h0, 9'h100, 9'h0FF});
        // ring mode: A then B in turn
        bus(8'h00, 1'h1, 32'h7, r);
        bus(8'h00, 1'h1, 32'h46, r);
        for (i = 0; i < 4; i++)
            bus(8'h04, 1'h1, 32'h31 + i, r);
        rd(8'h14, stat(2));
        for (i = 0; i < 4; i++)
            rd(8'h0C, 32'h31 + i);
        // reset in mid run
        hresetn <= 1'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        // clock enable low: a control write must be lost
        ce <= 1'h0;
        bus(8'h00, 1'h1, 32'h4, r);
        ce <= 1'h1;
        rd(8'h00, 32'h1);
        rd(8'h14, stat(0));
        chk("straps", {30'h0, a_sec, b_sec}, 32'h0);
        give_verdict();
    end

    // watchdog over the whole run
    initial begin
        repeat (40000) @(posedge hclk);
        error_cnt++;
        give_verdict();
    end
endmodule : dfc_tb
